// >>> seau_params.svh
// Constants of the serial EEPROM access unit: register offsets, field
// positions, command codes, reset values and link timing.
// Assumes byte addresses on the register port and a 40 MHz system clock.
`ifndef SEAU_PARAMS_SVH
`define SEAU_PARAMS_SVH

`define SEAU_OFS_CTRL       12'h308
`define SEAU_OFS_ADDAT      12'h30c

`define SEAU_CTRL_START     0
`define SEAU_CTRL_ALOAD     4
`define SEAU_CTRL_PROG      5
`define SEAU_CTRL_RATE_LO   6
`define SEAU_CTRL_RATE_HI   7
`define SEAU_CTRL_STAT_LO   8
`define SEAU_CTRL_STAT_HI   15
`define SEAU_CTRL_CMD_LO    16
`define SEAU_CTRL_CMD_HI    23
`define SEAU_CTRL_SIZE      31
`define SEAU_AD_ADDR_LO     0
`define SEAU_AD_ADDR_HI     15
`define SEAU_AD_DATA_LO     16
`define SEAU_AD_DATA_HI     31

`define SEAU_CMD_STATUS_WR  8'h01
`define SEAU_CMD_WRITE      8'h02
`define SEAU_CMD_READ       8'h03
`define SEAU_CMD_WR_DIS     8'h04
`define SEAU_CMD_STATUS_RD  8'h05
`define SEAU_CMD_WR_EN      8'h06
`define SEAU_CMD_ERASE      8'hc7

`define SEAU_RATE_RST       2'h0
`define SEAU_CMD_RST        8'h00
`define SEAU_BYTE_RST       8'h00
`define SEAU_HALF_RST       16'h0000

`define SEAU_PRIMARY_MHZ    500
`define SEAU_CLK_PERIOD_NS  25
`define SEAU_BASE_DIV       128

`define SEAU_BITS_CMD       6'h08
`define SEAU_BITS_SHORT     6'h10
`define SEAU_BITS_A16       6'h28
`define SEAU_BITS_A24       6'h30
`define SEAU_TX_MSB         47

`endif

// >>> seau_pkg.sv
// Types of the serial EEPROM access unit.
// Assumes seau_params.svh supplies all numeric constants.
package seau_pkg;

	typedef logic [11:0] seau_addr_t;
	typedef logic [31:0] seau_word_t;
	typedef logic [7:0]  seau_cmd_t;

	typedef enum logic [2:0] {
		SEAU_IDLE  = 3'b000,
		SEAU_LOAD  = 3'b001,
		SEAU_SETUP = 3'b010,
		SEAU_SHIFT = 3'b011,
		SEAU_HOLD  = 3'b100,
		SEAU_FIN   = 3'b101
	} seau_state_t;

endpackage

// >>> seau_eeprom_access.sv
// Serial EEPROM access unit: two software registers and the engine that
// runs one command frame on a four-wire serial EEPROM link (mode 0).
// Assumes a 40 MHz clock, a same-clock register port and an EEPROM whose
// data output pin is asynchronous to that clock.
`timescale 1ns/1ps
`include "seau_params.svh"

module seau_eeprom_access (
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              is_upstream_i,
	input  wire logic              autoload_ok_i,
	input  wire logic              autoload_busy_i,
	input  wire seau_pkg::seau_addr_t reg_addr_i,
	input  wire seau_pkg::seau_word_t reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output seau_pkg::seau_word_t   reg_rdata_o,
	output logic                   busy_o,
	output logic                   ee_clk_o,
	output logic                   ee_cs_n_o,
	output logic                   ee_mosi_o,
	input  wire logic              ee_miso_i
);
	import seau_pkg::*;

	// Half period of the EEPROM clock in system cycles, rounded up so the
	// link never runs faster than the selected division of 500 MHz.
	function automatic logic [5:0] half_cycles(input logic [1:0] sel);
		int div_v;
		int ns_v;
		div_v = `SEAU_BASE_DIV << sel;
		ns_v  = (div_v * 1000) / (2 * `SEAU_PRIMARY_MHZ);
		return 6'((ns_v + `SEAU_CLK_PERIOD_NS - 1) / `SEAU_CLK_PERIOD_NS);
	endfunction

	seau_state_t state_r;
	seau_state_t state_nxt;

	logic [1:0]  rate_r;
	logic [1:0]  run_rate_r;
	seau_cmd_t   cmd_r;
	logic        size_r;
	logic        start_r;
	logic [7:0]  status_r;
	logic [15:0] addr_r;
	logic [15:0] data_r;
	seau_word_t  rdata_r;

	logic [47:0] tx_r;
	logic [15:0] rx_r;
	logic [5:0]  nbits_r;
	logic [5:0]  bitcnt_r;
	logic [5:0]  cnt_r;
	logic        sck_r;
	logic        cs_n_r;
	logic        miso_m_r;
	logic        miso_s_r;

	logic        ctrl_wr;
	logic        addat_wr;
	logic        tick;
	logic        running;
	logic        done;
	logic        prog_mode;

	// Software cannot reach the registers on a downstream port
	assign ctrl_wr  = reg_wr_i && is_upstream_i &&
		(reg_addr_i == `SEAU_OFS_CTRL);
	assign addat_wr = reg_wr_i && is_upstream_i &&
		(reg_addr_i == `SEAU_OFS_ADDAT);

	assign running   = (state_r == SEAU_SETUP) || (state_r == SEAU_SHIFT) ||
		(state_r == SEAU_HOLD) || (state_r == SEAU_FIN);
	assign tick      = running && (cnt_r == 6'h00);
	assign done      = (state_r == SEAU_FIN) && tick;
	assign prog_mode = !autoload_busy_i;

	assign reg_rdata_o = rdata_r;
	assign busy_o      = start_r;
	assign ee_clk_o    = sck_r;
	assign ee_cs_n_o   = cs_n_r;
	assign ee_mosi_o   = tx_r[`SEAU_TX_MSB];

	// Pin synchroniser; only the second stage feeds the shifter
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			miso_m_r <= 1'b0;
			miso_s_r <= 1'b0;
		end else begin
			miso_m_r <= ee_miso_i;
			miso_s_r <= miso_m_r;
		end
	end

	// Control register fields written by software
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rate_r <= `SEAU_RATE_RST;
			cmd_r  <= `SEAU_CMD_RST;
			size_r <= 1'b0;
		end else if (ctrl_wr) begin
			rate_r <= reg_wdata_i[`SEAU_CTRL_RATE_HI:`SEAU_CTRL_RATE_LO];
			cmd_r  <= reg_wdata_i[`SEAU_CTRL_CMD_HI:`SEAU_CTRL_CMD_LO];
			size_r <= reg_wdata_i[`SEAU_CTRL_SIZE];
		end
	end

	// Start bit: a write of one while idle sets it, completion clears it.
	// A second start during an access is dropped, never queued.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			start_r <= 1'b0;
		end else if (done) begin
			start_r <= 1'b0;
		end else if (ctrl_wr && reg_wdata_i[`SEAU_CTRL_START]) begin
			start_r <= 1'b1;
		end
	end

	// Location of the access
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr_r <= `SEAU_HALF_RST;
		end else if (addat_wr) begin
			addr_r <= reg_wdata_i[`SEAU_AD_ADDR_HI:`SEAU_AD_ADDR_LO];
		end
	end

	// Data word: software writes it, a completed read replaces it.
	// First byte on the link is the low byte.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			data_r <= `SEAU_HALF_RST;
		end else if (done && (cmd_r == `SEAU_CMD_READ)) begin
			data_r <= {rx_r[7:0], rx_r[15:8]};
		end else if (addat_wr) begin
			data_r <= reg_wdata_i[`SEAU_AD_DATA_HI:`SEAU_AD_DATA_LO];
		end
	end

	// Last status byte returned by the EEPROM
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_r <= `SEAU_BYTE_RST;
		end else if (done && (cmd_r == `SEAU_CMD_STATUS_RD)) begin
			status_r <= rx_r[7:0];
		end
	end

	// Read port: data valid only in the cycle after the strobe
	// Cleared otherwise so a stale word never lingers on the bus
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= '0;
			if (reg_rd_i && is_upstream_i) begin
				case (reg_addr_i)
					`SEAU_OFS_CTRL: begin
						rdata_r[`SEAU_CTRL_START]   <= start_r;
						rdata_r[`SEAU_CTRL_ALOAD]   <= autoload_ok_i;
						rdata_r[`SEAU_CTRL_PROG]    <= prog_mode;
						rdata_r[`SEAU_CTRL_RATE_HI:`SEAU_CTRL_RATE_LO] <= rate_r;
						rdata_r[`SEAU_CTRL_STAT_HI:`SEAU_CTRL_STAT_LO] <=
							status_r;
						rdata_r[`SEAU_CTRL_CMD_HI:`SEAU_CTRL_CMD_LO] <= cmd_r;
						rdata_r[`SEAU_CTRL_SIZE]    <= size_r;
					end
					`SEAU_OFS_ADDAT: begin
						rdata_r <= {data_r, addr_r};
					end
					default: begin
						rdata_r <= '0;
					end
				endcase
			end
		end
	end

	// Engine sequencing
	// Launch waits while the autoload engine owns the link
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SEAU_IDLE: begin
				if (start_r && !autoload_busy_i) begin
					state_nxt = SEAU_LOAD;
				end
			end
			SEAU_LOAD: begin
				state_nxt = SEAU_SETUP;
			end
			SEAU_SETUP: begin
				if (tick) begin
					state_nxt = SEAU_SHIFT;
				end
			end
			SEAU_SHIFT: begin
				// Leave on the falling edge after the last sampled bit
				if (tick && sck_r && (bitcnt_r == nbits_r)) begin
					state_nxt = SEAU_HOLD;
				end
			end
			SEAU_HOLD: begin
				if (tick) begin
					state_nxt = SEAU_FIN;
				end
			end
			SEAU_FIN: begin
				if (tick) begin
					state_nxt = SEAU_IDLE;
				end
			end
			default: begin
				state_nxt = SEAU_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= SEAU_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Rate held for the whole frame, so a stray write during an access
	// cannot stretch or shrink a half period; it applies to the next one.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			run_rate_r <= `SEAU_RATE_RST;
		end else if (state_r == SEAU_IDLE) begin
			run_rate_r <= rate_r;
		end
	end

	// Half-period divider, reloaded from the rate held for this frame
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_r <= 6'h00;
		end else if (state_r == SEAU_LOAD || tick) begin
			cnt_r <= half_cycles(run_rate_r) - 6'h01;
		end else if (running) begin
			cnt_r <= cnt_r - 6'h01;
		end
	end

	// Link clock and chip select
	// Select follows the next state, so it leads the first rising edge
	// by two half periods and trails the last one by another two
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sck_r  <= 1'b0;
			cs_n_r <= 1'b1;
		end else begin
			if (state_r == SEAU_SHIFT && tick) begin
				sck_r <= !sck_r;
			end else if (state_r != SEAU_SHIFT) begin
				sck_r <= 1'b0;
			end
			cs_n_r <= !(state_nxt == SEAU_SETUP || state_nxt == SEAU_SHIFT ||
				state_nxt == SEAU_HOLD);
		end
	end

	// Frame assembly at launch; out data change on falling edges
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_r    <= '0;
			nbits_r <= `SEAU_BITS_CMD;
		end else if (state_r == SEAU_LOAD) begin
			case (cmd_r)
				`SEAU_CMD_STATUS_WR: begin
					tx_r    <= {cmd_r, data_r[7:0], 32'h0000_0000};
					nbits_r <= `SEAU_BITS_SHORT;
				end
				`SEAU_CMD_WRITE: begin
					// Large parts take three address bytes; the field has
					// only sixteen bits, so the top byte goes out as zero
					if (size_r) begin
						tx_r    <= {cmd_r, `SEAU_BYTE_RST, addr_r,
							data_r[7:0], data_r[15:8]};
						nbits_r <= `SEAU_BITS_A24;
					end else begin
						tx_r    <= {cmd_r, addr_r, data_r[7:0],
							data_r[15:8], `SEAU_BYTE_RST};
						nbits_r <= `SEAU_BITS_A16;
					end
				end
				`SEAU_CMD_READ: begin
					if (size_r) begin
						tx_r    <= {cmd_r, `SEAU_BYTE_RST, addr_r, 16'h0000};
						nbits_r <= `SEAU_BITS_A24;
					end else begin
						tx_r    <= {cmd_r, addr_r, 24'h00_0000};
						nbits_r <= `SEAU_BITS_A16;
					end
				end
				`SEAU_CMD_STATUS_RD: begin
					tx_r    <= {cmd_r, 40'h00_0000_0000};
					nbits_r <= `SEAU_BITS_SHORT;
				end
				default: begin
					// Write enable, write disable, erase and unknown codes
					// are a bare opcode frame
					tx_r    <= {cmd_r, 40'h00_0000_0000};
					nbits_r <= `SEAU_BITS_CMD;
				end
			endcase
		end else if (state_r == SEAU_SHIFT && tick && sck_r) begin
			tx_r <= {tx_r[46:0], 1'b0};
		end else if (state_r == SEAU_FIN) begin
			tx_r <= '0;
		end
	end

	// Bit counter and receive shifter; sampled on rising edges
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bitcnt_r <= 6'h00;
			rx_r     <= `SEAU_HALF_RST;
		end else if (state_r == SEAU_LOAD) begin
			bitcnt_r <= 6'h00;
			rx_r     <= `SEAU_HALF_RST;
		end else if (state_r == SEAU_SHIFT && tick && !sck_r) begin
			bitcnt_r <= bitcnt_r + 6'h01;
			rx_r     <= {rx_r[14:0], miso_s_r};
		end
	end

endmodule

// >>> seau_eeprom_access_properties.sv
// Port checks of the EEPROM access unit.
// Assumes the ports of seau_eeprom_access and one clock.
`timescale 1ns/1ps
`include "seau_params.svh"
module seau_eeprom_access_props (
	input wire logic                 clk_i,
	input wire logic                 reset_n_i,
	input wire logic                 is_upstream_i,
	input wire logic                 autoload_ok_i,
	input wire logic                 autoload_busy_i,
	input wire seau_pkg::seau_addr_t reg_addr_i,
	input wire seau_pkg::seau_word_t reg_wdata_i,
	input wire logic                 reg_wr_i,
	input wire logic                 reg_rd_i,
	input wire seau_pkg::seau_word_t reg_rdata_o,
	input wire logic                 busy_o,
	input wire logic                 ee_clk_o,
	input wire logic                 ee_cs_n_o,
	input wire logic                 ee_mosi_o,
	input wire logic                 ee_miso_i
);
	import seau_pkg::*;
	logic [1:0] rate_r;
	int         hi_r;
	int         half;
	logic       go;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	assign half = rate_r == 2'h0 ? 6 : rate_r == 2'h1 ? 11 :
		rate_r == 2'h2 ? 21 : 41;
	assign go = reg_wr_i && is_upstream_i && reg_addr_i == `SEAU_OFS_CTRL;
	// Rate mirror; software keeps it still during frames
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) rate_r <= `SEAU_RATE_RST;
		else if (go) rate_r <= reg_wdata_i[7:6];
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) hi_r <= 0;
		else hi_r <= ee_clk_o ? hi_r + 1 : 0;
	end
	a_idle_cs_high: assert property (!busy_o |-> ee_cs_n_o)
		else $error("select low while idle");
	a_idle_clk_low: assert property (ee_cs_n_o |-> !ee_clk_o)
		else $error("clock runs outside frame");
	a_idle_mosi_low: assert property (ee_cs_n_o |-> !ee_mosi_o)
		else $error("serial out high while idle");
	a_start_sets_busy: assert property (go && reg_wdata_i[0] &&
		!busy_o && !autoload_busy_i |=> busy_o)
		else $error("start not taken");
	a_frame_opens_soon: assert property ($rose(busy_o) &&
		!autoload_busy_i |-> ##[1:3] !ee_cs_n_o)
		else $error("frame late");
	a_read_data_once: assert property (!$past(reg_rd_i) |->
		reg_rdata_o == 32'h0)
		else $error("read data outside slot");
	a_hidden_reads_zero: assert property ($past(reg_rd_i) &&
		!$past(is_upstream_i) |-> reg_rdata_o == 32'h0)
		else $error("hidden register read");
	a_half_period: assert property ($fell(ee_clk_o) |-> hi_r == half)
		else $error("wrong clock half period");
	a_mosi_steady: assert property ($rose(ee_clk_o) |->
		$stable(ee_mosi_o))
		else $error("serial out moved at rise");
	c_frame: cover property ($fell(ee_cs_n_o));
	c_done: cover property ($fell(busy_o));
	c_slow: cover property ($fell(ee_clk_o) && rate_r == 2'h3);
endmodule
bind seau_eeprom_access seau_eeprom_access_props chk (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .is_upstream_i(is_upstream_i),
	.autoload_ok_i(autoload_ok_i), .autoload_busy_i(autoload_busy_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.busy_o(busy_o), .ee_clk_o(ee_clk_o), .ee_cs_n_o(ee_cs_n_o),
	.ee_mosi_o(ee_mosi_o), .ee_miso_i(ee_miso_i));

// >>> seau_eeprom_model.sv
// Behavioural serial EEPROM, one stored word, link mode 0.
// Assumes chip select frames every command.
`timescale 1ns/1ps
module seau_eeprom_model (
	input  wire logic ee_clk_i,
	input  wire logic ee_cs_n_i,
	input  wire logic ee_mosi_i,
	output logic      ee_miso_o
);
	logic [7:0]  op_r, stat_r, sv;
	logic [15:0] sh_r, word_r, addr_r, rw;
	logic        wel_r = 1'b0;
	int          cnt_r = 0;
	assign sv = {stat_r[7:2], wel_r, stat_r[0]};
	assign rw = {word_r[7:0], word_r[15:8]};
	initial begin
		{op_r, stat_r, sh_r, word_r, addr_r} = '0;
		ee_miso_o = 1'b0;
	end
	always @(negedge ee_cs_n_i) begin
		cnt_r = 0;
		op_r = 8'h00;
	end
	always @(posedge ee_clk_i) if (!ee_cs_n_i) begin
		sh_r = {sh_r[14:0], ee_mosi_i};
		cnt_r++;
		if (cnt_r == 8) op_r = sh_r[7:0];
		if (cnt_r == 24) addr_r = sh_r;
		if (wel_r && op_r == 8'h01 && cnt_r == 16) stat_r = sh_r[7:0];
		if (wel_r && op_r == 8'h02 && cnt_r == 32) word_r[7:0] = sh_r[7:0];
		if (wel_r && op_r == 8'h02 && cnt_r == 40) word_r[15:8] = sh_r[7:0];
	end
	// Unused slots toggle so a stale bit cannot pass
	always @(negedge ee_clk_i) if (!ee_cs_n_i) begin
		if (op_r == 8'h05 && cnt_r >= 8 && cnt_r < 16)
			ee_miso_o = sv[15 - cnt_r];
		else if (op_r == 8'h03 && cnt_r >= 24 && cnt_r < 40)
			ee_miso_o = rw[39 - cnt_r];
		else
			ee_miso_o = ~ee_miso_o;
	end
	always @(posedge ee_cs_n_i) begin
		if (op_r == 8'hc7 && wel_r) word_r = 16'hffff;
		wel_r = op_r == 8'h06 || (wel_r && op_r inside {8'h03, 8'h05});
		ee_miso_o = ~ee_miso_o;
	end
endmodule

// >>> seau_eeprom_access_tb.sv
// Bench of the EEPROM access unit against the EEPROM model.
// Assumes the checker is bound to the unit.
`timescale 1ns/1ps
`include "seau_params.svh"
module seau_eeprom_access_tb;
	import seau_pkg::*;
	logic       clk_i, reset_n_i, up, ok, abusy, wr, rd;
	logic       busy, sclk, cs_n, mosi, miso;
	seau_addr_t addr;
	seau_word_t wdata, rdata, d;
	int         errors = 0, num_checks = 0, cycles = 0;
	seau_eeprom_access uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.is_upstream_i(up), .autoload_ok_i(ok), .autoload_busy_i(abusy),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .busy_o(busy), .ee_clk_o(sclk),
		.ee_cs_n_o(cs_n), .ee_mosi_o(mosi), .ee_miso_i(miso));
	seau_eeprom_model mem (.ee_clk_i(sclk), .ee_cs_n_i(cs_n),
		.ee_mosi_i(mosi), .ee_miso_o(miso));
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input seau_word_t got, input seau_word_t exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input seau_addr_t a, input seau_word_t v);
		@(posedge clk_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input seau_addr_t a);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic run(input logic [7:0] c, input logic sz,
		input logic [1:0] r);
		int n;
		wr_reg(`SEAU_OFS_CTRL, {sz, 7'h00, c, 8'h00, r, 6'h01});
		#1 chk({31'h0, busy}, 32'h1);
		n = 0;
		while (busy !== 1'b0 && n < 9000) begin
			@(posedge clk_i);
			n++;
		end
		#1 chk({31'h0, busy}, 32'h0);
	endtask
	task automatic t_reset;
		rd_reg(`SEAU_OFS_CTRL);
		chk(d, 32'h30);
		rd_reg(`SEAU_OFS_ADDAT);
		chk(d, 32'h0);
		rd_reg(12'h310);
		chk(d, 32'h0);
		@(posedge clk_i);
		abusy <= 1'b1;
		ok <= 1'b0;
		rd_reg(`SEAU_OFS_CTRL);
		chk(d, 32'h0);
		@(posedge clk_i);
		abusy <= 1'b0;
		ok <= 1'b1;
	endtask
	task automatic t_write;
		wr_reg(`SEAU_OFS_ADDAT, 32'ha55a1234);
		run(8'h06, 1'b0, 2'h0);
		run(8'h02, 1'b0, 2'h0);
		chk(mem.word_r, 32'ha55a);
		chk(mem.addr_r, 32'h1234);
		chk(mem.cnt_r, 40);
		wr_reg(`SEAU_OFS_ADDAT, 32'h00001234);
		run(8'h03, 1'b0, 2'h0);
		rd_reg(`SEAU_OFS_ADDAT);
		chk(d, 32'ha55a1234);
	endtask
	task automatic t_hidden;
		@(posedge clk_i);
		up <= 1'b0;
		wr_reg(`SEAU_OFS_ADDAT, 32'h0);
		rd_reg(`SEAU_OFS_ADDAT);
		chk(d, 32'h0);
		@(posedge clk_i);
		up <= 1'b1;
		rd_reg(`SEAU_OFS_ADDAT);
		chk(d, 32'ha55a1234);
	endtask
	task automatic t_status;
		wr_reg(`SEAU_OFS_ADDAT, 32'h008c0000);
		run(8'h06, 1'b0, 2'h0);
		run(8'h01, 1'b0, 2'h0);
		run(8'h05, 1'b0, 2'h0);
		rd_reg(`SEAU_OFS_CTRL);
		chk(d, 32'h00058c30);
	endtask
	task automatic t_guard;
		wr_reg(`SEAU_OFS_ADDAT, 32'h11110042);
		run(8'h06, 1'b0, 2'h0);
		run(8'h04, 1'b0, 2'h0);
		run(8'h02, 1'b0, 2'h0);
		chk(mem.word_r, 32'ha55a);
		run(8'h06, 1'b0, 2'h0);
		run(8'hc7, 1'b0, 2'h0);
		run(8'h03, 1'b0, 2'h0);
		rd_reg(`SEAU_OFS_ADDAT);
		chk(d, 32'hffff0042);
		run(8'h02, 1'b1, 2'h0);
		chk(mem.cnt_r, 48);
	endtask
	task automatic t_rate;
		for (int r = 0; r < 4; r++) begin
			run(8'h04, 1'b0, r[1:0]);
			rd_reg(`SEAU_OFS_CTRL);
			chk({30'h0, d[7:6]}, r);
		end
	endtask
	// Reset in the middle of a slow frame must idle the link at once
	task automatic t_midreset;
		wr_reg(`SEAU_OFS_CTRL, {8'h00, 8'h04, 8'h00, 2'h3, 6'h01});
		repeat (200) @(posedge clk_i);
		#1 chk({31'h0, cs_n}, 32'h0);
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		@(posedge clk_i);
		#1 chk({28'h0, busy, sclk, cs_n, mosi}, 32'h2);
		@(posedge clk_i);
		reset_n_i <= 1'b1;
		rd_reg(`SEAU_OFS_CTRL);
		chk(d, 32'h30);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Ceiling well above the slowest frames in the run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		{reset_n_i, wr, rd, abusy, up, ok} = 6'h03;
		addr = '0;
		wdata = '0;
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_write();
		t_hidden();
		t_status();
		t_guard();
		t_rate();
		t_midreset();
		summarize();
	end
endmodule
